/* File: dv/testbench.sv */
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdw_pkg::*;
    localparam logic [16:0] BT = 17'h4;  // Short base period keeps runs brief
    logic        aclk, aresetn, irq_req, rtc_run, irq_any, rtc_clk;
    logic [3:0]  s_awaddr, s_araddr, s_wstrb;
    logic [31:0] s_wdata, s_rdata, d;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, sys_rst_req, cpu_rst_req;
    logic [1:0]  s_bresp, s_rresp, r, wh;
    wdw_pwr_s    pwr;
    int          miscompares, checked, cyc, seed, wn, ln, ticks, m_ctrl;

    wdw_top #(.BASE_TICKS(BT)) u_wdw_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .rtc_clk(rtc_clk), .irq_any(irq_any), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .sys_rst_req(sys_rst_req), .cpu_rst_req(cpu_rst_req), .pwr(pwr));
    wdw_irq_src u_wdw_irq_src (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
        .rtc_run(rtc_run), .irq_any(irq_any), .rtc_clk(rtc_clk));

    // Clock and hang guard
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Write cycle: both channels offered at once, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= v;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_awready) begin
                aw_ok = 1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready) begin
                w_ok = 1;
                s_wvalid <= 1'b0;
            end
        end
        while (!s_bvalid) @(posedge aclk);
        rs = s_bresp;
        s_bready <= 1'b0;
    endtask

    // Read cycle: rready held from the start so the answer is never missed
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        v = s_rdata;
        rs = s_rresp;
        s_rready <= 1'b0;
    endtask

    // Waits up to lim cycles for a reset pulse, then measures its length
    task automatic watch(input int lim, output int w, output logic [1:0] h, output int n);
        w = -1;
        h = 2'b00;
        n = 0;
        for (int i = 0; i < lim && w < 0; i++) begin
            @(posedge aclk);
            if (sys_rst_req || cpu_rst_req) begin
                w = i;
                h = {sys_rst_req, cpu_rst_req};
            end
        end
        while (w >= 0 && (sys_rst_req || cpu_rst_req)) begin
            n++;
            @(posedge aclk);
        end
    endtask

    // Model of the power controls for each sleep code
    function automatic logic [4:0] exp_pwr(input int c);
        case (c)
            1: return 5'h10;
            2: return 5'h0c;
            3: return 5'h0f;
            default: return 5'h00;
        endcase
    endfunction

    // Main sequence
    initial begin
        {aclk, aresetn, irq_req, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
        rtc_run = 1'b1;
        seed = 57929;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(WDW_CTRL_OFF, d, r);
        `CHK(d, 32'h15)
        rd(WDW_SLP_OFF, d, r);
        `CHK(d, 32'h0)
        rd(4'h2, d, r);
        `CHK(r, WDW_RESP_DEC)
        wr(4'h6, 32'h0, r);
        `CHK(r, WDW_RESP_DEC)
        // Every period step, alternating the reset target
        for (int s = 0; s < 6; s++) begin
            m_ctrl = 1 | ((s % 2) << 1) | (s << 2);
            ticks = int'(BT) << s;
            wr(WDW_CTRL_OFF, 32'(m_ctrl), r);
            wr(WDW_CLR_OFF, 32'ha005, r);
            watch(ticks * 8 + 40, wn, wh, ln);
            wr(WDW_CLR_OFF, 32'ha005, r);
            `CHK(wh, (s % 2) ? 2'b01 : 2'b10)
            `CHK(ln, 8)
            `CHK(wn >= (ticks - 1) * 8 - 4 && wn <= ticks * 8 + 8, 1'b1)
            rd(WDW_STAT_OFF, d, r);
            `CHK(d, 32'h4)
            wr(WDW_STAT_OFF, 32'h4, r);
        end
        // Keys with random middle bits hold it off, a wrong key does not
        wr(WDW_CTRL_OFF, 32'h5, r);
        for (int k = 0; k < 10; k++) begin
            wr(WDW_CLR_OFF, {16'h0, 4'ha, 8'($random(seed)), 4'h5}, r);
            watch(40, wn, wh, ln);
            `CHK(wh, 2'b00)
        end
        wr(WDW_CLR_OFF, 32'h5aa5, r);
        watch(40, wn, wh, ln);
        `CHK(wh, 2'b10)
        // No slow ticks, no timeout
        wr(WDW_CTRL_OFF, 32'h1, r);
        rtc_run <= 1'b0;
        wr(WDW_CLR_OFF, 32'ha005, r);
        watch(200, wn, wh, ln);
        `CHK(wh, 2'b00)
        rtc_run <= 1'b1;
        watch(60, wn, wh, ln);
        `CHK(wh, 2'b10)
        wr(WDW_CTRL_OFF, 32'h0, r);
        watch(400, wn, wh, ln);
        `CHK(wh, 2'b00)
        // Timeouts above left the fired flag set; clear it before the sleep checks
        rd(WDW_STAT_OFF, d, r);
        `CHK(d, 32'h4)
        wr(WDW_STAT_OFF, 32'h4, r);
        // Idle code and each sleep code with the watchdog off, woken by an interrupt
        for (int c = 0; c < 4; c++) begin
            wr(WDW_SLP_OFF, 32'(c), r);
            repeat (2) @(posedge aclk);
            `CHK(pwr, exp_pwr(c))
            rd(WDW_SLP_OFF, d, r);
            `CHK(d, 32'(c))
            irq_req <= 1'b1;
            watch(20, wn, wh, ln);
            `CHK(wh, (c >= 2) ? 2'b01 : 2'b00)
            irq_req <= 1'b0;
            `CHK(pwr, 5'h00)
            rd(WDW_STAT_OFF, d, r);
            `CHK(d, (c == 0) ? 32'h0 : 32'h8)
            wr(WDW_STAT_OFF, 32'h8, r);
        end
        // Watchdog keeps running in wait and halt, stops in standby
        for (int c = 1; c < 4; c++) begin
            wr(WDW_CTRL_OFF, 32'h5, r);
            wr(WDW_CLR_OFF, 32'ha005, r);
            wr(WDW_SLP_OFF, 32'(c), r);
            watch(90, wn, wh, ln);
            `CHK(wh, (c == 3) ? 2'b00 : 2'b10)
            irq_req <= 1'b1;
            watch(20, wn, wh, ln);
            `CHK(wh, (c == 3) ? 2'b01 : 2'b00)
            irq_req <= 1'b0;
        end
        close_out();
    end
endmodule
`default_nettype wire

/* File: dv/wdw_irq_src.sv */
`default_nettype none
module wdw_irq_src (
    input  wire logic aclk,     // System clock
    input  wire logic aresetn,  // Sync reset, active low
    input  wire logic irq_req,  // Bench asks for an interrupt
    input  wire logic rtc_run,  // Slow oscillator running
    output logic      irq_any,  // Interrupt line into the block
    output logic      rtc_clk   // Slow clock, eight system cycles a period
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q;

    // Slow clock freezes at its level when stopped, like a dead oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 3'h0;
        end else if (rtc_run) begin
            div_q <= div_q + 3'h1;
        end
    end
    assign rtc_clk = div_q[2];

    // Source holds its request level until the bench withdraws it
    always_ff @(posedge aclk) begin
        irq_any <= aresetn & irq_req;
    end
endmodule
`default_nettype wire

/* File: rtl/wdw_pkg.sv */
`default_nettype none
package wdw_pkg;
    // Clock and timing
    localparam int          WDW_CLK_NS        = 8;
    localparam longint      WDW_RTC_HZ        = 32768;
    localparam longint      WDW_MIN_PERIOD_US = 62500;
    localparam logic [16:0] WDW_MIN_TICKS     =
        17'((WDW_MIN_PERIOD_US * WDW_RTC_HZ) / 64'd1000000);
    localparam int          WDW_RSTP_NS       = 64;
    localparam logic [3:0]  WDW_RSTP_CYC      =
        4'((WDW_RSTP_NS + WDW_CLK_NS - 1) / WDW_CLK_NS);

    // Period select: tick count is the minimum period shifted by sel
    localparam logic [2:0]  WDW_SEL_MAX = 3'h5;
    localparam logic [2:0]  WDW_SEL_RST = 3'h5;
    localparam logic        WDW_EN_RST  = 1'b1;
    localparam logic        WDW_CPU_RST = 1'b0;

    // Register map (byte addresses)
    localparam int          WDW_AW       = 4;
    localparam logic [3:0]  WDW_CTRL_OFF = 4'h0;
    localparam logic [3:0]  WDW_CLR_OFF  = 4'h4;
    localparam logic [3:0]  WDW_SLP_OFF  = 4'h8;
    localparam logic [3:0]  WDW_STAT_OFF = 4'hc;

    // Field positions
    localparam int WDW_CTRL_EN_BIT  = 0;
    localparam int WDW_CTRL_CPU_BIT = 1;
    localparam int WDW_CTRL_SEL_LSB = 2;
    localparam int WDW_STAT_FIRED   = 2;
    localparam int WDW_STAT_WOKE    = 3;

    // Clear key nibbles
    localparam logic [3:0] WDW_KEY_HI = 4'ha;
    localparam logic [3:0] WDW_KEY_LO = 4'h5;

    // Sleep request codes
    localparam logic [1:0] WDW_SLP_WAIT = 2'h1;
    localparam logic [1:0] WDW_SLP_HALT = 2'h2;
    localparam logic [1:0] WDW_SLP_STBY = 2'h3;

    // Bus responses
    localparam logic [1:0] WDW_RESP_OK  = 2'h0;
    localparam logic [1:0] WDW_RESP_DEC = 2'h3;

    typedef enum logic [1:0] {WDW_RUN, WDW_WAIT, WDW_HALT, WDW_STBY} wdw_mode_e;

    typedef struct packed {
        logic       en;
        logic       cpu_only;
        logic [2:0] sel;
    } wdw_ctrl_s;

    typedef struct packed {
        logic cpu_stall;
        logic cpu_off;
        logic pll_off;
        logic mods_off;
        logic retain;
    } wdw_pwr_s;
endpackage
`default_nettype wire

/* File: rtl/wdw_tick.sv */
`default_nettype none
module wdw_tick (
    input  wire logic aclk,     // System clock
    input  wire logic aresetn,  // Sync reset, active low
    input  wire logic ce,       // Clock enable
    input  wire logic rtc_clk,  // 32768 Hz clock, sampled
    output logic      tick      // One pulse per rtc rising edge
);
    logic prev_q;
    logic prev_d;
    logic tick_q;
    logic tick_d;

    // Rising edge of the slow clock becomes a one-cycle tick
    always_comb begin
        prev_d = rtc_clk;
        tick_d = rtc_clk & ~prev_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b1;  // A slow clock already high at release is no edge
            tick_q <= 1'b0;
        end else if (ce) begin
            prev_q <= prev_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

/* File: rtl/wdw_top.sv */
`default_nettype none
// How it works
// RULE1: A missed clear resets the system or only the processor, as the control bit picks.
// RULE2: Clearing the enable bit stops the watchdog so no watchdog reset can occur.
// RULE3: The period runs from 62.5 ms to 2 s in doubling steps, 2 s after reset.
// RULE4: A write of a word with top nibble a and bottom nibble 5 to the clear port restarts it; the code checks bits 15:12 for a and needs wstrb[1:0] set.
// RULE5: The watchdog keeps counting in wait and halt, where the slow clock still runs.
// RULE6: After reset the block runs until software asks for wait, halt or standby.
// RULE7: Any interrupt while in a low-power mode wakes the device.
// RULE8: Waking from wait resumes the processor with no reset.
// RULE9: Waking from halt or standby resets the processor to its start point.
// RULE10: Halt turns the processor and the clock multiplier off, leaving the slow domain on.
// RULE11: Standby turns all modules off while memory and pin states are retained.
// RULE12: The timeout counter advances only on ticks taken from the 32768 Hz clock.
module wdw_top #(
    parameter logic [16:0] BASE_TICKS = wdw_pkg::WDW_MIN_TICKS  // Ticks of shortest period
) (
    input  wire logic                   aclk,          // System clock
    input  wire logic                   aresetn,       // Sync reset, active low
    input  wire logic                   ce,            // Clock enable
    input  wire logic                   rtc_clk,       // 32768 Hz clock input
    input  wire logic                   irq_any,       // Any interrupt pending
    input  wire logic [wdw_pkg::WDW_AW-1:0] s_awaddr,  // Write address
    input  wire logic                   s_awvalid,     // Write address valid
    output logic                        s_awready,     // Write address ready
    input  wire logic [31:0]            s_wdata,       // Write data
    input  wire logic [3:0]             s_wstrb,       // Byte strobes
    input  wire logic                   s_wvalid,      // Write data valid
    output logic                        s_wready,      // Write data ready
    output logic [1:0]                  s_bresp,       // Write response
    output logic                        s_bvalid,      // Write response valid
    input  wire logic                   s_bready,      // Write response ready
    input  wire logic [wdw_pkg::WDW_AW-1:0] s_araddr,  // Read address
    input  wire logic                   s_arvalid,     // Read address valid
    output logic                        s_arready,     // Read address ready
    output logic [31:0]                 s_rdata,       // Read data
    output logic [1:0]                  s_rresp,       // Read response
    output logic                        s_rvalid,      // Read data valid
    input  wire logic                   s_rready,      // Read data ready
    output logic                        sys_rst_req,   // Whole-system reset pulse
    output logic                        cpu_rst_req,   // Processor-only reset pulse
    output wdw_pkg::wdw_pwr_s           pwr            // Power-domain controls
);
    import wdw_pkg::*;

    // Register decode, shared by write and read paths
    function automatic logic addr_hit(input logic [WDW_AW-1:0] a);
        addr_hit = (a == WDW_CTRL_OFF) || (a == WDW_CLR_OFF) ||
                   (a == WDW_SLP_OFF) || (a == WDW_STAT_OFF);
    endfunction

    // Out-of-range selects clamp to the longest period
    function automatic logic [16:0] period_ticks(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > WDW_SEL_MAX) ? WDW_SEL_MAX : sel;
        period_ticks = BASE_TICKS << s;
    endfunction

    logic              aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [WDW_AW-1:0] awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic              wr_en;

    wdw_ctrl_s   ctrl_q, ctrl_d;
    wdw_mode_e   mode_q, mode_d;
    wdw_pwr_s    pwr_q, pwr_d;
    logic [16:0] cnt_q, cnt_d;
    logic [3:0]  rcnt_q, rcnt_d;
    logic        sys_q, sys_d, cpu_q, cpu_d, fired_q, fired_d, woke_q, woke_d;
    logic        tick, wd_run, kick, expire, wake, ev_sys, ev_cpu;

    wdw_tick u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .rtc_clk (rtc_clk),
        .tick    (tick)
    );

    // Bus slave: address and data are taken in either order, one write at a time
    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (s_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_awaddr;
        end
        if (s_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        wr_en = aw_got_q && w_got_q && !bvalid_q;
        if (bvalid_q && s_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_en) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = addr_hit(awaddr_q) ? WDW_RESP_OK : WDW_RESP_DEC;
        end
        if (rvalid_q && s_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = addr_hit(s_araddr) ? WDW_RESP_OK : WDW_RESP_DEC;
            case (s_araddr)
                WDW_CTRL_OFF: rdata_d = {27'h0, ctrl_q.sel, ctrl_q.cpu_only, ctrl_q.en};
                WDW_SLP_OFF:  rdata_d = {30'h0, mode_q};
                WDW_STAT_OFF: rdata_d = {28'h0, woke_q, fired_q, mode_q};
                default:      rdata_d = 32'h0;
            endcase
        end
        // Readies drop while a transfer is held, so the master sees back-pressure
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= WDW_RESP_OK;
            rvalid_q  <= 1'b0;
            rresp_q   <= WDW_RESP_OK;
            rdata_q   <= 32'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else if (ce) begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    // Watchdog, power mode and reset pulses
    always_comb begin
        ctrl_d  = ctrl_q;
        mode_d  = mode_q;
        cnt_d   = cnt_q;
        rcnt_d  = rcnt_q;
        sys_d   = sys_q;
        cpu_d   = cpu_q;
        fired_d = fired_q;
        woke_d  = woke_q;
        // Standby stops the slow clock, so the count is cleared and held at zero there
        wd_run  = ctrl_q.en && (mode_q != WDW_STBY);                 // [RULE2] [RULE5]
        kick    = wr_en && (awaddr_q == WDW_CLR_OFF) && (wstrb_q[1:0] == 2'h3) &&
                  (wdata_q[15:12] == WDW_KEY_HI) && (wdata_q[3:0] == WDW_KEY_LO); // [RULE4]
        expire  = wd_run && tick && !kick &&
                  (cnt_q >= period_ticks(ctrl_q.sel) - 17'h1);       // [RULE3] [RULE12]
        wake    = (mode_q != WDW_RUN) && irq_any;                    // [RULE7]
        ev_sys  = expire && !ctrl_q.cpu_only;                        // [RULE1]
        ev_cpu  = (expire && ctrl_q.cpu_only) ||
                  (wake && (mode_q != WDW_WAIT));                    // [RULE1] [RULE9]
        if (!wd_run || kick) begin
            cnt_d = 17'h0;                                           // [RULE4]
        end else if (tick) begin
            cnt_d = expire ? 17'h0 : cnt_q + 17'h1;                  // [RULE12]
        end
        if (wr_en && (awaddr_q == WDW_CTRL_OFF) && wstrb_q[0]) begin
            ctrl_d.en       = wdata_q[WDW_CTRL_EN_BIT];              // [RULE2]
            ctrl_d.cpu_only = wdata_q[WDW_CTRL_CPU_BIT];
            ctrl_d.sel      = wdata_q[WDW_CTRL_SEL_LSB +: 3];        // [RULE3]
        end
        if (wr_en && (awaddr_q == WDW_SLP_OFF) && wstrb_q[0] && (mode_q == WDW_RUN)) begin
            case (wdata_q[1:0])
                WDW_SLP_WAIT: mode_d = WDW_WAIT;                     // [RULE6]
                WDW_SLP_HALT: mode_d = WDW_HALT;
                WDW_SLP_STBY: mode_d = WDW_STBY;
                default:      mode_d = WDW_RUN;
            endcase
        end
        // Wait returns to the next instruction; among wakes only halt and standby raise ev_cpu, as does a cpu_only timeout
        if (wake || expire) begin
            mode_d = WDW_RUN;                                        // [RULE8] [RULE9]
        end
        // Sticky flags, write one to clear; a same-cycle set wins
        if (wr_en && (awaddr_q == WDW_STAT_OFF) && wstrb_q[0]) begin
            fired_d = fired_q & ~wdata_q[WDW_STAT_FIRED];
            woke_d  = woke_q & ~wdata_q[WDW_STAT_WOKE];
        end
        fired_d = fired_d | expire;
        woke_d  = woke_d | wake;
        // Stretched pulse; events arriving mid-pulse extend it
        if (ev_sys || ev_cpu) begin
            rcnt_d = WDW_RSTP_CYC;                                   // [RULE1]
            sys_d  = sys_q | ev_sys;
            cpu_d  = cpu_q | ev_cpu;
        end else if (rcnt_q != 4'h0) begin
            rcnt_d = rcnt_q - 4'h1;
            if (rcnt_q == 4'h1) begin
                sys_d = 1'b0;
                cpu_d = 1'b0;
            end
        end
        pwr_d.cpu_stall = (mode_d == WDW_WAIT);
        pwr_d.cpu_off   = (mode_d == WDW_HALT) || (mode_d == WDW_STBY); // [RULE10]
        pwr_d.pll_off   = (mode_d == WDW_HALT) || (mode_d == WDW_STBY); // [RULE10]
        pwr_d.mods_off  = (mode_d == WDW_STBY);                      // [RULE11]
        pwr_d.retain    = (mode_d == WDW_STBY);                      // [RULE11]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= '{en: WDW_EN_RST, cpu_only: WDW_CPU_RST, sel: WDW_SEL_RST}; // [RULE3]
            mode_q  <= WDW_RUN;                                      // [RULE6]
            cnt_q   <= 17'h0;
            rcnt_q  <= 4'h0;
            sys_q   <= 1'b0;
            cpu_q   <= 1'b0;
            fired_q <= 1'b0;
            woke_q  <= 1'b0;
            pwr_q   <= '0;
        end else if (ce) begin
            ctrl_q  <= ctrl_d;
            mode_q  <= mode_d;
            cnt_q   <= cnt_d;
            rcnt_q  <= rcnt_d;
            sys_q   <= sys_d;
            cpu_q   <= cpu_d;
            fired_q <= fired_d;
            woke_q  <= woke_d;
            pwr_q   <= pwr_d;
        end
    end

    assign s_awready   = awready_q;
    assign s_wready    = wready_q;
    assign s_bvalid    = bvalid_q;
    assign s_bresp     = bresp_q;
    assign s_arready   = arready_q;
    assign s_rvalid    = rvalid_q;
    assign s_rresp     = rresp_q;
    assign s_rdata     = rdata_q;
    assign sys_rst_req = sys_q;
    assign cpu_rst_req = cpu_q;
    assign pwr         = pwr_q;

    // Checks on the watchdog and power sequencing
    clear_restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
        ce && kick |=> cnt_q == 17'h0) else $error("clear did not restart count");
    wd_disabled_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
        ce && !ctrl_q.en && rcnt_q == 4'h0 && !wake |=> !sys_q && !cpu_q)
        else $error("reset while watchdog disabled");
    expire_target_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
        ce && expire && rcnt_q == 4'h0 && !wake |=>
        (sys_q != cpu_q) && (cpu_q == $past(ctrl_q.cpu_only)))
        else $error("timeout reset went to wrong target");
    pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
        $rose(sys_q) |-> sys_q [*8]) else $error("system reset pulse too short");
    reset_period_a: assert property (@(posedge aclk) // [RULE3]
        aresetn && !$past(aresetn) |-> ctrl_q.sel == WDW_SEL_RST && ctrl_q.en)
        else $error("period not 2 s after reset");
    run_at_reset_a: assert property (@(posedge aclk) // [RULE6]
        aresetn && !$past(aresetn) |-> mode_q == WDW_RUN && pwr_q == '0)
        else $error("not running after reset");
    wait_resume_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
        ce && mode_q == WDW_WAIT && irq_any && !expire && rcnt_q == 4'h0 |=>
        mode_q == WDW_RUN && !cpu_q && !pwr_q.cpu_stall)
        else $error("wait wake did not resume cleanly");
    deep_restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
        ce && (mode_q == WDW_HALT || mode_q == WDW_STBY) && irq_any |=>
        cpu_q && mode_q == WDW_RUN && woke_q) else $error("deep wake without cpu reset");
    halt_power_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
        ce && mode_d == WDW_HALT |=> pwr_q.cpu_off && pwr_q.pll_off && !pwr_q.mods_off)
        else $error("halt power state wrong");
    stby_retain_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
        mode_q == WDW_STBY |-> pwr_q.retain && pwr_q.mods_off)
        else $error("standby without retention");
    halt_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
        ce && tick && mode_q == WDW_HALT && ctrl_q.en && !kick && !expire |=>
        cnt_q == $past(cnt_q) + 17'h1) else $error("watchdog stalled in halt");
    tick_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
        ce && !tick && !kick && wd_run |=> $stable(cnt_q))
        else $error("count moved without slow tick");
endmodule
`default_nettype wire
